// >>> bench/cdsc_assertions.sv
`timescale 1ns/1ps
module cdsc_checker (
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic        IRQ_I,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic [2:0]  DOZE_RATIO_O,
  input wire logic [3:0]  FRC_DIV_SHIFT_O,
  input wire logic [1:0]  VCO_DIV_SHIFT_O,
  input wire logic [9:0]  PLL_MULT_O,
  input wire logic [2:0]  SYS_SOURCE_O,
  input wire logic        MONITOR_EN_O,
  input wire logic        SWITCH_BUSY_O
);
  // --------------------
  // Settle counter
  // --------------------
  // Counts cycles after reset so that the config capture is not read as a switch.
  logic [3:0] settle;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  always_ff @(posedge CLK_I) begin
    if (SRST_I) settle <= 4'h0;
    else if (settle != 4'hf) settle <= settle + 4'h1;
  end
  a_busy_when_off: assert property (!MONITOR_EN_O |-> !SWITCH_BUSY_O)
    else $error("Switch request set while switching is off.");
  a_mult_range: assert property (PLL_MULT_O >= 10'h2 && PLL_MULT_O <= 10'h201)
    else $error("Multiplier out of range.");
  a_frc_legal: assert property (FRC_DIV_SHIFT_O <= 4'h8 && FRC_DIV_SHIFT_O != 4'h7)
    else $error("Postscale shift illegal.");
  a_vco_legal: assert property (VCO_DIV_SHIFT_O != 2'h0)
    else $error("Output divider shift illegal.");
  a_src_hold: assert property (settle == 4'hf && !SWITCH_BUSY_O && !$past(SWITCH_BUSY_O)
    && !$past(SWITCH_BUSY_O, 2) |-> $stable(SYS_SOURCE_O))
    else $error("Source changed with no switch.");
  a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("Upper read bits not zero.");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("Read answer late.");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("Write answer late.");
  a_read_drop: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("Read answer held too long.");
  a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("Read address taken while answer pending.");
  c_switch_done: cover property ($fell(SWITCH_BUSY_O));
  c_read_err: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
  c_irq_doze: cover property (IRQ_I && DOZE_RATIO_O != 3'h0);
endmodule

bind cdsc_top cdsc_checker u_chk (.CLK_I, .SRST_I, .IRQ_I, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP, .DOZE_RATIO_O,
  .FRC_DIV_SHIFT_O, .VCO_DIV_SHIFT_O, .PLL_MULT_O, .SYS_SOURCE_O, .MONITOR_EN_O,
  .SWITCH_BUSY_O);

// >>> bench/test_clock_divider_switch_control.sv
`timescale 1ns/1ps
`include "cdsc_params.svh"
module test_clock_divider_switch_control import cdsc_pkg::*;;
  logic        clk = 1'b0, srst = 1'b1, irq = 1'b0, cfg_off = 1'b1, rdy = 1'b1;
  logic [7:0]  src = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, mon, busy;
  logic [1:0]  bresp, rresp, bseen, rr, vco, subm;
  logic [2:0]  doze, sysrc;
  logic [3:0]  fast_internal_rc;
  logic [4:0]  pre;
  logic [9:0]  mult;
  logic [5:0]  trim;
  logic [15:0] v;
  int          failures = 0, checks = 0;
  always #2.5 clk = ~clk;
  cdsc_top u_dut (.CLK_I(clk), .SRST_I(srst), .CE_I(1'b1), .IRQ_I(irq),
    .SWITCH_MONITOR_DISABLE_CFG_I(cfg_off), .INITIAL_SOURCE_CFG_I(3'h7),
    .PRIMARY_SUBMODE_CFG_I(2'h2), .SRC_CLK_I(src), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(rdy),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rdy),
    .DOZE_RATIO_O(doze), .FRC_DIV_SHIFT_O(fast_internal_rc), .VCO_DIV_SHIFT_O(vco),
    .PLL_INPUT_PRESCALE_O(pre), .PLL_MULT_O(mult), .FRC_TRIM_O(trim),
    .SYS_SOURCE_O(sysrc), .PRIMARY_SUBMODE_O(subm), .MONITOR_EN_O(mon),
    .SWITCH_BUSY_O(busy));
  // --------------------
  // Bus tasks
  // --------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] x);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {16'h0000, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bseen = bresp;
    if (n >= 50) begin
      failures++;
      close_out();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    d = rdata;
    rr = rresp;
    if (n >= 50) begin
      failures++;
      close_out();
    end
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk(s, {16'h0000, e}, d);
  endtask
  task automatic unlock();
    wr(`CDSC_OFF_KEY, {8'h00, `CDSC_KEY1});
    wr(`CDSC_OFF_KEY, {8'h00, `CDSC_KEY2});
  endtask
  task automatic pulse(input logic [7:0] m, input int k);
    repeat (k) begin
      src <= m;
      idle(4);
      src <= 8'h00;
      idle(4);
    end
  endtask
  task automatic rst();
    srst <= 1'b1;
    idle(10);
    srst <= 1'b0;
    idle(6);
  endtask
  task automatic close_out();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // --------------------
  // Tests
  // --------------------
  initial begin
    idle(20000);
    failures++;
    close_out();
  end
  initial begin
    rst();
    rc("div", `CDSC_OFF_DIV, 16'h3040);
    rc("fbd", `CDSC_OFF_FBD, 16'h0030);
    rc("tun", `CDSC_OFF_TUN, 16'h0000);
    chk("mult", 32'h32, mult);
    chk("mon", 32'h0, mon);
    unlock();
    wr(`CDSC_OFF_OSC, 16'h0201);
    idle(3);
    chk("busy", 32'h0, busy);
    rd(`CDSC_OFF_OSC);
    chk("osc0", 32'h0, d[0]);
    chk("src", 32'h7, sysrc);
    wr(`CDSC_OFF_DIV, 16'hffff);
    rc("div", `CDSC_OFF_DIV, 16'hffdf);
    wr(`CDSC_OFF_FBD, 16'hffff);
    rc("fbd", `CDSC_OFF_FBD, 16'h01ff);
    chk("mult", 32'h201, mult);
    wr(`CDSC_OFF_TUN, 16'hffff);
    rc("tun", `CDSC_OFF_TUN, 16'h003f);
    wr(`CDSC_OFF_TUN, 16'h0020);
    idle(2);
    chk("trim", 32'h20, trim);
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 3'h0, i[2:0]};
      wr(`CDSC_OFF_DIV, v);
      idle(2);
      chk("doze", i, doze);
      chk("frc", (i == 7) ? 8 : i, fast_internal_rc);
      chk("vco", (i[1:0] == 2'h0) ? 1 : ((i[1:0] == 2'h3) ? 3 : 2), vco);
      chk("pre", i, pre);
      rc("div", `CDSC_OFF_DIV, v);
    end
    wr(`CDSC_OFF_DIV, 16'h5000);
    idle(2);
    chk("doze", 32'h0, doze);
    wr(`CDSC_OFF_DIV, 16'hd800);
    irq <= 1'b1;
    idle(1);
    irq <= 1'b0;
    idle(3);
    chk("doze", 32'h0, doze);
    rc("div", `CDSC_OFF_DIV, 16'hd000);
    wr(`CDSC_OFF_DIV, 16'h5800);
    irq <= 1'b1;
    idle(1);
    irq <= 1'b0;
    idle(3);
    chk("doze", 32'h5, doze);
    rd(8'h14);
    chk("rresp", 32'h2, rr);
    chk("rdata", 32'h0, d);
    wr(8'h14, 16'h1234);
    chk("bresp", 32'h2, bseen);
    cfg_off <= 1'b0;
    rst();
    rc("div", `CDSC_OFF_DIV, 16'h3040);
    chk("mon", 32'h1, mon);
    wr(`CDSC_OFF_OSC, 16'h0501);
    idle(3);
    chk("busy", 32'h0, busy);
    unlock();
    wr(`CDSC_OFF_OSC, 16'h0701);
    idle(4);
    chk("busy", 32'h0, busy);
    unlock();
    wr(`CDSC_OFF_OSC, 16'h0501);
    idle(2);
    chk("busy", 32'h1, busy);
    pulse(8'h80, 12);
    pulse(8'h20, 9);
    chk("busy", 32'h1, busy);
    pulse(8'h20, 1);
    idle(4);
    chk("busy", 32'h0, busy);
    chk("src", 32'h5, sysrc);
    rc("osc", `CDSC_OFF_OSC, 16'h5500);
    chk("subm", 32'h2, subm);
    close_out();
  end
endmodule

// >>> rtl/cdsc_params.svh
// Functional notes
// R1 - With recover_on_interrupt set, an interrupt clears reduction_enable, ratio back to 1:1.
// R2 - proc_clock_reduction divides processor clock by 2^code; reset code 011.
// R3 - reduction_enable clear forces the peripheral/processor ratio to 1:1.
// R4 - fast_rc_postscale divides by 1..64 for 000..110 and by 256 for 111.
// R5 - vco_output_divider: 00 /2, 01 /4 default, 11 /8, 10 reserved.
// R6 - pll_feedback_divisor gives multiplier code plus two; reset code gives 50.
// R7 - fast_rc_trim is signed offset, 0.375 percent steps, 100000 lowest.
// R8 - The three divider and trim registers reset only on power-on reset.
// R9 - Unimplemented bits read zero and ignore writes.
// R10 - When permitted, software switches among sources; an unlock sequence guards it.
// R11 - Primary submode is fixed by configuration; software cannot change it.
// R12 - Switching enabled only when switch_monitor_disable_cfg is zero; one disables monitor too.
// R13 - With switching disabled, current_source_status follows initial_source_cfg.
// R14 - With switching disabled, switch_request has no effect and reads zero.
// R15 - A request to the current source is redundant: clear switch_request, abort.
// R16 - Valid switch waits 10 new-source cycles, clears request, copies new to current.
`ifndef CDSC_PARAMS_SVH
`define CDSC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define CDSC_OFF_DIV    8'h00
`define CDSC_OFF_FBD    8'h04
`define CDSC_OFF_TUN    8'h08
`define CDSC_OFF_OSC    8'h0c
`define CDSC_OFF_KEY    8'h10

// ----------------------------------------------------------------------------
// Reset values and keys
// ----------------------------------------------------------------------------
`define CDSC_RST_DOZE   3'h3
`define CDSC_RST_POST   2'h1
`define CDSC_RST_FBD    9'h030
`define CDSC_KEY1       8'h46
`define CDSC_KEY2       8'h57
`define CDSC_RESP_OK    2'h0
`define CDSC_RESP_ERR   2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CDSC_SRC_CYCLES 4'ha
`define CDSC_CFG_SETTLE 2'h2

`endif

// >>> rtl/cdsc_pkg.sv
package cdsc_pkg;

  typedef enum logic [1:0] {
    CDSC_SW_IDLE = 2'b01,
    CDSC_SW_WAIT = 2'b10
  } cdsc_sw_state_t;

  typedef struct packed {
    logic [7:0]     s1;
    logic [7:0]     s2;
    logic [7:0]     s3;
    cdsc_sw_state_t st;
    logic [2:0]     sel;
    logic [3:0]     cnt;
    logic           done;
  } cdsc_sw_regs_t;

  typedef struct packed {
    logic [5:0]  cfg_s1;
    logic [5:0]  cfg_s2;
    logic [1:0]  ld_cnt;
    logic        loaded;
    logic [1:0]  submode;
    logic        recover_on_interrupt;
    logic [2:0]  doze;
    logic        reduction_enable;
    logic [2:0]  fast_rc_postscale;
    logic [1:0]  vco_output_divider;
    logic [4:0]  pll_input_prescale;
    logic [8:0]  pll_feedback_divisor;
    logic [5:0]  fast_rc_trim;
    logic [2:0]  new_source_select;
    logic [2:0]  current_source_status;
    logic        switch_request;
    logic        chk;
    logic        sw_start;
    logic [1:0]  unlock;
    logic        aw_full;
    logic [7:0]  awaddr;
    logic        w_full;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [15:0] rdata;
    logic [2:0]  doze_ratio;
    logic [3:0]  frc_shift;
    logic [1:0]  vco_shift;
    logic [9:0]  pll_mult;
    logic        mon_en;
  } cdsc_regs_t;

endpackage

// >>> rtl/cdsc_switch.sv
`timescale 1ns/1ps
`include "cdsc_params.svh"

module cdsc_switch
  import cdsc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       start_i,
  input  wire logic [2:0] sel_i,
  input  wire logic [7:0] src_clk_i,
  output logic            done_o
);

  cdsc_sw_regs_t r;
  cdsc_sw_regs_t next_r;
  logic          rise;

  // --------------------------------------------------------------------------
  // Source clocks are sampled twice, then edge detected on the third stage.
  // --------------------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.s1   = src_clk_i;
    next_r.s2   = r.s1;
    next_r.s3   = r.s2;
    next_r.done = 1'b0;
    rise        = r.s2[r.sel] & ~r.s3[r.sel];
    case (r.st)
      CDSC_SW_IDLE: begin
        if (start_i) begin
          next_r.sel = sel_i;
          next_r.cnt = 4'h0;
          next_r.st  = CDSC_SW_WAIT;
        end
      end
      CDSC_SW_WAIT: begin
        if (rise) begin
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt == `CDSC_SRC_CYCLES - 4'h1) begin // R16
            next_r.done = 1'b1;
            next_r.st   = CDSC_SW_IDLE;
          end
        end
      end
      default: begin
        next_r.st = CDSC_SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r    <= '0;
      r.st <= CDSC_SW_IDLE;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign done_o = r.done;

endmodule

// >>> rtl/cdsc_top.sv
`timescale 1ns/1ps
`include "cdsc_params.svh"

module cdsc_top
  import cdsc_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        CE_I,
  input  wire logic        IRQ_I,
  input  wire logic        SWITCH_MONITOR_DISABLE_CFG_I,
  input  wire logic [2:0]  INITIAL_SOURCE_CFG_I,
  input  wire logic [1:0]  PRIMARY_SUBMODE_CFG_I,
  input  wire logic [7:0]  SRC_CLK_I,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [2:0]       DOZE_RATIO_O,
  output logic [3:0]       FRC_DIV_SHIFT_O,
  output logic [1:0]       VCO_DIV_SHIFT_O,
  output logic [4:0]       PLL_INPUT_PRESCALE_O,
  output logic [9:0]       PLL_MULT_O,
  output logic [5:0]       FRC_TRIM_O,
  output logic [2:0]       SYS_SOURCE_O,
  output logic [1:0]       PRIMARY_SUBMODE_O,
  output logic             MONITOR_EN_O,
  output logic             SWITCH_BUSY_O
);

  cdsc_regs_t  r;
  cdsc_regs_t  next_r;
  logic        sw_done;
  logic        sw_en;
  logic        do_wr;
  logic [15:0] wd;
  logic [15:0] rd;
  logic        rd_err;

  // --------------------------------------------------------------------------
  // Waits for the selected new source to run before the switch completes.
  // --------------------------------------------------------------------------
  cdsc_switch u_switch (
    .clk_i     (CLK_I),
    .srst_i    (SRST_I),
    .ce_i      (CE_I),
    .start_i   (r.sw_start),
    .sel_i     (r.new_source_select),
    .src_clk_i (SRC_CLK_I),
    .done_o    (sw_done)
  );

  // --------------------------------------------------------------------------
  // Next-state logic.
  // --------------------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.cfg_s1   = {PRIMARY_SUBMODE_CFG_I, INITIAL_SOURCE_CFG_I,
                       SWITCH_MONITOR_DISABLE_CFG_I};
    next_r.cfg_s2   = r.cfg_s1;
    next_r.sw_start = 1'b0;
    sw_en           = r.loaded & ~r.cfg_s2[0]; // R12
    wd              = r.wdata;
    rd              = 16'h0000;
    rd_err          = 1'b0;

    // Configuration is taken once the pin synchronisers have settled.
    if (!r.loaded) begin
      next_r.ld_cnt = r.ld_cnt + 2'h1;
      if (r.ld_cnt == `CDSC_CFG_SETTLE) begin
        next_r.loaded  = 1'b1;
        next_r.submode = r.cfg_s2[5:4]; // R11
        next_r.current_source_status    = r.cfg_s2[3:1];
        next_r.new_source_select    = r.cfg_s2[3:1];
      end
    end

    // Write channel capture; address and data may come in either order.
    if (S_AXI_AWVALID && r.awready) begin
      next_r.aw_full = 1'b1;
      next_r.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && r.wready) begin
      next_r.w_full = 1'b1;
      next_r.wdata  = S_AXI_WDATA[15:0];
      next_r.wstrb  = S_AXI_WSTRB[1:0];
    end
    if (r.bvalid && S_AXI_BREADY) begin
      next_r.bvalid = 1'b0;
    end

    do_wr = r.aw_full & r.w_full & ~r.bvalid;
    if (do_wr) begin
      next_r.aw_full = 1'b0;
      next_r.w_full  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = `CDSC_RESP_OK;
      next_r.unlock  = 2'h0;
      case (r.awaddr)
        `CDSC_OFF_DIV: begin
          if (r.wstrb[1]) begin
            next_r.recover_on_interrupt    = wd[15];
            next_r.doze   = wd[14:12]; // R2
            next_r.reduction_enable  = wd[11];
            next_r.fast_rc_postscale = wd[10:8];
          end
          if (r.wstrb[0]) begin
            next_r.vco_output_divider = wd[7:6];
            next_r.pll_input_prescale  = wd[4:0]; // R9
          end
        end
        `CDSC_OFF_FBD: begin
          if (r.wstrb[1]) begin
            next_r.pll_feedback_divisor[8] = wd[8]; // R9
          end
          if (r.wstrb[0]) begin
            next_r.pll_feedback_divisor[7:0] = wd[7:0];
          end
        end
        `CDSC_OFF_TUN: begin
          if (r.wstrb[0]) begin
            next_r.fast_rc_trim = wd[5:0]; // R7 R9
          end
        end
        `CDSC_OFF_OSC: begin
          if (r.unlock == 2'h2 && sw_en && !r.switch_request) begin // R10
            if (r.wstrb[1]) begin
              next_r.new_source_select = wd[10:8];
            end
            if (r.wstrb[0] && wd[0]) begin
              next_r.switch_request = 1'b1;
              next_r.chk   = 1'b1;
            end
          end
        end
        `CDSC_OFF_KEY: begin
          if (r.wstrb[0] && wd[7:0] == `CDSC_KEY1) begin
            next_r.unlock = 2'h1;
          end else if (r.wstrb[0] && r.unlock == 2'h1 && wd[7:0] == `CDSC_KEY2) begin
            next_r.unlock = 2'h2;
          end
        end
        default: begin
          next_r.bresp = `CDSC_RESP_ERR;
        end
      endcase
    end

    // Switch sequence.
    if (r.chk) begin
      next_r.chk = 1'b0;
      if (r.new_source_select == r.current_source_status) begin
        next_r.switch_request = 1'b0; // R15
      end else begin
        next_r.sw_start = 1'b1;
      end
    end
    if (sw_done) begin
      next_r.switch_request = 1'b0; // R16
      next_r.current_source_status  = r.new_source_select;
    end
    if (r.loaded && !sw_en) begin
      next_r.switch_request    = 1'b0; // R14
      next_r.chk      = 1'b0;
      next_r.sw_start = 1'b0;
      next_r.current_source_status     = r.cfg_s2[3:1]; // R13
    end

    // An interrupt wins over a software write in the same cycle.
    if (IRQ_I && r.recover_on_interrupt) begin
      next_r.reduction_enable = 1'b0; // R1
    end

    // Read channel.
    case (S_AXI_ARADDR)
      `CDSC_OFF_DIV: rd = {r.recover_on_interrupt, r.doze, r.reduction_enable, r.fast_rc_postscale, r.vco_output_divider, 1'b0, r.pll_input_prescale};
      `CDSC_OFF_FBD: rd = {7'h00, r.pll_feedback_divisor}; // R9
      `CDSC_OFF_TUN: rd = {10'h000, r.fast_rc_trim}; // R9
      `CDSC_OFF_OSC: rd = {1'b0, r.current_source_status, 1'b0, r.new_source_select, 7'h00, r.switch_request};
      `CDSC_OFF_KEY: rd = {14'h0000, r.unlock};
      default:       rd_err = 1'b1;
    endcase
    if (r.rvalid && S_AXI_RREADY) begin
      next_r.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd;
      next_r.rresp  = rd_err ? `CDSC_RESP_ERR : `CDSC_RESP_OK;
    end

    next_r.awready = ~next_r.aw_full & ~next_r.bvalid;
    next_r.wready  = ~next_r.w_full & ~next_r.bvalid;
    next_r.arready = ~next_r.rvalid;

    // Registered clock-control outputs.
    next_r.doze_ratio = next_r.reduction_enable ? next_r.doze : 3'h0; // R3
    next_r.frc_shift  = (next_r.fast_rc_postscale == 3'h7) ? 4'h8 : {1'b0, next_r.fast_rc_postscale}; // R4
    case (next_r.vco_output_divider)
      2'h0:    next_r.vco_shift = 2'h1; // R5
      2'h3:    next_r.vco_shift = 2'h3;
      default: next_r.vco_shift = 2'h2;
    endcase
    next_r.pll_mult = {1'b0, next_r.pll_feedback_divisor} + 10'h002; // R6
    next_r.mon_en   = next_r.loaded & ~next_r.cfg_s2[0];
  end

  // --------------------------------------------------------------------------
  // State register; SRST_I is the power-on reset.
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      r            <= '0; // R8
      r.doze       <= `CDSC_RST_DOZE;
      r.vco_output_divider    <= `CDSC_RST_POST;
      r.pll_feedback_divisor     <= `CDSC_RST_FBD;
      r.vco_shift  <= 2'h2;
      r.pll_mult   <= {1'b0, `CDSC_RST_FBD} + 10'h002;
    end else if (CE_I) begin
      r <= next_r;
    end
  end

  assign S_AXI_AWREADY        = r.awready;
  assign S_AXI_WREADY         = r.wready;
  assign S_AXI_BVALID         = r.bvalid;
  assign S_AXI_BRESP          = r.bresp;
  assign S_AXI_ARREADY        = r.arready;
  assign S_AXI_RVALID         = r.rvalid;
  assign S_AXI_RRESP          = r.rresp;
  assign S_AXI_RDATA          = {16'h0000, r.rdata};
  assign DOZE_RATIO_O         = r.doze_ratio;
  assign FRC_DIV_SHIFT_O      = r.frc_shift;
  assign VCO_DIV_SHIFT_O      = r.vco_shift;
  assign PLL_INPUT_PRESCALE_O = r.pll_input_prescale;
  assign PLL_MULT_O           = r.pll_mult;
  assign FRC_TRIM_O           = r.fast_rc_trim;
  assign SYS_SOURCE_O         = r.current_source_status;
  assign PRIMARY_SUBMODE_O    = r.submode;
  assign MONITOR_EN_O         = r.mon_en;
  assign SWITCH_BUSY_O        = r.switch_request;

endmodule
